/* File: design/slrb_bank.sv */
`timescale 1ns/10ps
`default_nettype none
`include "slrb_params.svh"
module slrb_bank
  import slrb_pkg::*;
(
  input wire logic sys_clk, // System clock 50 MHz
  input wire logic resetn, // Sync reset, active low
  input wire slrb_pkg::slrb_byte_t sfr_addr, // CPU register address
  input wire slrb_pkg::slrb_byte_t sfr_wdata, // CPU write data
  input wire logic sfr_wr, // CPU write strobe
  output slrb_pkg::slrb_byte_t sfr_rdata, // CPU read data
  output logic sfr_hit, // Address is ours
  input wire logic no_control_field_mode, // Mode register bit 1
  input wire logic rx_frame_start, // Link: frame begins
  input wire logic rx_byte, // Link: info byte arrived
  input wire logic rx_frame_done, // Link: good frame ended
  input wire logic rx_numbered, // Frame carries counts
  input wire slrb_pkg::slrb_cnt_t peer_ns, // Received send count
  input wire slrb_pkg::slrb_cnt_t peer_nr, // Received receive count
  input wire logic rx_opt_poll, // Unnumbered poll, poll bit zero
  input wire logic tx_frame_start, // Link: transmit begins
  input wire logic tx_byte, // Link: info byte sent
  input wire logic tx_frame_done, // Link: transmit ended
  input wire logic auto_rts_set, // Auto: link raises send request
  input wire logic auto_rts_clr, // Auto: link drops send request
  input wire logic auto_leave, // Link drops auto select
  input wire logic opb_set, // Link sets optional poll bit
  input wire logic opb_clr, // Link clears optional poll bit
  input wire logic ovr_clr, // Link clears overrun
  output slrb_pkg::slrb_mode_e link_mode, // Effective mode
  output logic rx_store_en, // Storing into receive buffer
  output slrb_pkg::slrb_byte_t rx_ram_addr, // Receive RAM address
  output logic rx_buf_end, // Receive buffer end
  output slrb_pkg::slrb_byte_t tx_ram_addr, // Transmit RAM address
  output logic tx_more, // Transmit bytes remain
  output slrb_pkg::slrb_byte_t tx_ctrl, // Outgoing control field
  output logic tx_ctrl_present, // Control field sent
  output logic opt_poll_answer, // Auto reply to optional poll
  output slrb_pkg::slrb_byte_t station_addr, // Station address
  output logic rts_out, // Request-to-send level
  output logic link_irq // Interrupt flag level
);
  import slrb_pkg::*;

  // ----------------------------------------
  // Register storage
  // ----------------------------------------
  slrb_byte_t sts_ff;
  slrb_byte_t seq_ff;
  slrb_byte_t station_ff;
  slrb_byte_t tx_start_ptr_ff;
  slrb_byte_t tx_len_ff;
  slrb_byte_t tx_ctrl_byte_ff;
  slrb_byte_t rx_start_ptr_ff;
  slrb_byte_t rx_area_len_ff;
  slrb_byte_t rdata_ff;
  logic in_rx_ff;
  logic wr_sts, wr_seq, rx_err, tx_err, auto_on, rx_active;
  slrb_byte_t nxt_sts;
  slrb_byte_t nxt_seq;

  // Strobes for the two registers that the link also edits
  assign wr_sts = sfr_wr && (sfr_addr == `SLRB_ADDR_STS);
  assign wr_seq = sfr_wr && (sfr_addr == `SLRB_ADDR_SEQ);

  // ----------------------------------------
  // Mode decode
  // ----------------------------------------
  // Without control field the select bit means addressed, not auto
  always_comb begin
    if (!sts_ff[`SLRB_B_AUTO]) begin
      link_mode = SLRB_M_FLEX;
    end else if (no_control_field_mode) begin
      link_mode = SLRB_M_ADDR;
    end else begin
      link_mode = SLRB_M_AUTO;
    end
  end
  assign auto_on = (link_mode == SLRB_M_AUTO);

  // ----------------------------------------
  // Status register: link events win over CPU writes
  // ----------------------------------------
  always_comb begin
    nxt_sts = wr_sts ? sfr_wdata : sts_ff;
    if (auto_leave) nxt_sts[`SLRB_B_AUTO] = 1'b0;
    if (opb_clr) nxt_sts[`SLRB_B_OPB] = 1'b0;
    if (opb_set) nxt_sts[`SLRB_B_OPB] = 1'b1;
    if (ovr_clr) nxt_sts[`SLRB_B_OVR] = 1'b0;
    // Overrun: byte arrived with no room left or storing blocked
    if (rx_byte && in_rx_ff && !(rx_active && !sts_ff[`SLRB_B_PROT])) begin
      nxt_sts[`SLRB_B_OVR] = 1'b1;
    end
    if (auto_on && auto_rts_clr) nxt_sts[`SLRB_B_RTS] = 1'b0;
    if (auto_on && auto_rts_set) nxt_sts[`SLRB_B_RTS] = 1'b1;
    if (tx_frame_done) nxt_sts[`SLRB_B_TBF] = 1'b0;
    if (rx_frame_done && in_rx_ff) nxt_sts[`SLRB_B_RXE] = 1'b0;
    // A completed transmit frame, or a receive frame while tracked, interrupts; set beats a CPU clear
    if ((rx_frame_done && in_rx_ff) || tx_frame_done) begin
      nxt_sts[`SLRB_B_IRQ] = 1'b1;
    end
  end

  // Status flops; cleared so the link comes up idle
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      sts_ff <= `SLRB_RST_BYTE;
    end else begin
      sts_ff <= nxt_sts;
    end
  end

  // ----------------------------------------
  // Sequence counts, auto mode only
  // ----------------------------------------
  slrb_seq_check u_seq (
    .local_ns(seq_ff[7:5]),
    .local_nr(seq_ff[3:1]),
    .peer_ns(peer_ns),
    .peer_nr(peer_nr),
    .recv_err(rx_err),
    .send_err(tx_err)
  );

  always_comb begin
    nxt_seq = wr_seq ? sfr_wdata : seq_ff;
    // Non-auto modes never touch the counts
    if (auto_on && rx_frame_done && in_rx_ff && rx_numbered) begin
      nxt_seq[0] = rx_err;
      nxt_seq[4] = tx_err;
      if (!rx_err && !sts_ff[`SLRB_B_PROT]) begin
        nxt_seq[3:1] = slrb_cnt_t'(seq_ff[3:1] + 3'h1);
      end
    end
    if (auto_on && tx_frame_done && rx_numbered) begin
      nxt_seq[7:5] = slrb_cnt_t'(seq_ff[7:5] + 3'h1);
    end
  end

  // Sequence flops; counts restart at zero
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      seq_ff <= `SLRB_RST_BYTE;
    end else begin
      seq_ff <= nxt_seq;
    end
  end

  // ----------------------------------------
  // Parameter registers, CPU written only
  // ----------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      station_ff <= `SLRB_RST_BYTE;
      tx_start_ptr_ff <= `SLRB_RST_BYTE;
      tx_len_ff <= `SLRB_RST_BYTE;
      tx_ctrl_byte_ff <= `SLRB_RST_BYTE;
      rx_start_ptr_ff <= `SLRB_RST_BYTE;
      rx_area_len_ff <= `SLRB_RST_BYTE;
    end else if (sfr_wr) begin
      case (sfr_addr)
        `SLRB_ADDR_STATION_ADDR: station_ff <= sfr_wdata;
        `SLRB_ADDR_TXPTR: tx_start_ptr_ff <= sfr_wdata;
        `SLRB_ADDR_TXLEN: tx_len_ff <= sfr_wdata;
        `SLRB_ADDR_TCB: tx_ctrl_byte_ff <= sfr_wdata;
        `SLRB_ADDR_RXPTR: rx_start_ptr_ff <= sfr_wdata;
        `SLRB_ADDR_RXLEN: rx_area_len_ff <= sfr_wdata;
        default: station_ff <= station_ff;
      endcase
    end
  end

  // ----------------------------------------
  // Read path, registered; unmapped reads zero
  // ----------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      rdata_ff <= `SLRB_RST_BYTE;
    end else begin
      case (sfr_addr)
        `SLRB_ADDR_STS: rdata_ff <= sts_ff;
        `SLRB_ADDR_SEQ: rdata_ff <= seq_ff;
        `SLRB_ADDR_STATION_ADDR: rdata_ff <= station_ff;
        `SLRB_ADDR_TXPTR: rdata_ff <= tx_start_ptr_ff;
        `SLRB_ADDR_TXLEN: rdata_ff <= tx_len_ff;
        `SLRB_ADDR_TCB: rdata_ff <= tx_ctrl_byte_ff;
        `SLRB_ADDR_RXPTR: rdata_ff <= rx_start_ptr_ff;
        `SLRB_ADDR_RXLEN: rdata_ff <= rx_area_len_ff;
        default: rdata_ff <= `SLRB_RST_BYTE;
      endcase
    end
  end
  assign sfr_rdata = rdata_ff;
  assign sfr_hit = (sfr_addr == `SLRB_ADDR_STS) || (sfr_addr == `SLRB_ADDR_SEQ) ||
    (sfr_addr == `SLRB_ADDR_STATION_ADDR) || (sfr_addr == `SLRB_ADDR_TXPTR) ||
    (sfr_addr == `SLRB_ADDR_TXLEN) || (sfr_addr == `SLRB_ADDR_TCB) ||
    (sfr_addr == `SLRB_ADDR_RXPTR) || (sfr_addr == `SLRB_ADDR_RXLEN);

  // ----------------------------------------
  // Receive frame tracking: only while enabled
  // ----------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      in_rx_ff <= 1'b0;
    end else if (rx_frame_start && sts_ff[`SLRB_B_RXE]) begin
      in_rx_ff <= 1'b1;
    end else if (rx_frame_done) begin
      in_rx_ff <= 1'b0;
    end
  end

  // ----------------------------------------
  // Buffer walkers
  // ----------------------------------------
  slrb_buf_addr u_rx_buf (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .start(rx_frame_start && sts_ff[`SLRB_B_RXE]),
    .base(rx_start_ptr_ff),
    .len(rx_area_len_ff),
    .step(rx_byte && !sts_ff[`SLRB_B_PROT]),
    .addr(rx_ram_addr),
    .active(rx_active),
    .buf_end(rx_buf_end)
  );

  slrb_buf_addr u_tx_buf (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .start(tx_frame_start),
    .base(tx_start_ptr_ff),
    .len(tx_len_ff),
    .step(tx_byte),
    .addr(tx_ram_addr),
    .active(tx_more),
    .buf_end()
  );

  // Protect bit blocks every store
  assign rx_store_en = rx_byte && in_rx_ff && rx_active && !sts_ff[`SLRB_B_PROT];

  // ----------------------------------------
  // Outgoing control field
  // ----------------------------------------
  // Auto mode builds its own supervisory reply; busy answer under protect
  always_comb begin
    if (auto_on) begin
      // Receive count acknowledges; bit 4 is the final bit, always set
      tx_ctrl[7:5] = seq_ff[3:1];
      tx_ctrl[4] = 1'b1;
      tx_ctrl[3:0] = sts_ff[`SLRB_B_PROT] ? `SLRB_CTL_RNR : `SLRB_CTL_RR;
    end else begin
      tx_ctrl = tx_ctrl_byte_ff;
    end
  end
  // Level outputs; station address, send request and interrupt straight from the registers
  assign tx_ctrl_present = !no_control_field_mode;
  assign opt_poll_answer = rx_opt_poll && auto_on && sts_ff[`SLRB_B_OPB];
  assign station_addr = station_ff;
  assign rts_out = sts_ff[`SLRB_B_RTS];
  assign link_irq = sts_ff[`SLRB_B_IRQ];

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  // Protect must freeze the walker too, or later bytes land past a gap
  chk_protect_store: assert property (@(posedge sys_clk) disable iff (!resetn)
    sts_ff[`SLRB_B_PROT] |-> !rx_store_en)
    else $error("store while protected");
  chk_protect_addr: assert property (@(posedge sys_clk) disable iff (!resetn)
    sts_ff[`SLRB_B_PROT] && !rx_frame_start |=> $stable(rx_ram_addr))
    else $error("receive address moved while protected");
  chk_irq_set_wins: assert property (@(posedge sys_clk) disable iff (!resetn)
    tx_frame_done |=> link_irq)
    else $error("interrupt flag not set");
  chk_irq_rx: assert property (@(posedge sys_clk) disable iff (!resetn)
    rx_frame_done && in_rx_ff |=> link_irq)
    else $error("receive frame did not interrupt");
  chk_rxe_clear: assert property (@(posedge sys_clk) disable iff (!resetn)
    rx_frame_done && in_rx_ff |=> !sts_ff[`SLRB_B_RXE])
    else $error("receive enable not cleared");
  chk_tbf_clear: assert property (@(posedge sys_clk) disable iff (!resetn)
    tx_frame_done |=> !sts_ff[`SLRB_B_TBF])
    else $error("transmit full not cleared");
  chk_seq_hold: assert property (@(posedge sys_clk) disable iff (!resetn)
    !auto_on && !wr_seq |=> $stable(seq_ff))
    else $error("counts moved outside auto mode");
  chk_rts_auto: assert property (@(posedge sys_clk) disable iff (!resetn)
    !auto_on && !wr_sts |=> $stable(sts_ff[`SLRB_B_RTS]))
    else $error("send request changed by link");
  chk_nr_wrap: assert property (@(posedge sys_clk) disable iff (!resetn)
    auto_on && rx_frame_done && in_rx_ff && rx_numbered && !rx_err &&
    !sts_ff[`SLRB_B_PROT] && !wr_seq && seq_ff[3:1] == 3'h7 |=> seq_ff[3:1] == 3'h0)
    else $error("receive count did not wrap");
  chk_ns_wrap: assert property (@(posedge sys_clk) disable iff (!resetn)
    auto_on && tx_frame_done && rx_numbered && !wr_seq && seq_ff[7:5] == 3'h7 |=>
    seq_ff[7:5] == 3'h0)
    else $error("send count did not wrap");
  chk_reset_idle: assert property (@(posedge sys_clk)
    !resetn |=> sts_ff == `SLRB_RST_BYTE && seq_ff == `SLRB_RST_BYTE)
    else $error("reset left link busy");
  chk_ovr_flag: assert property (@(posedge sys_clk) disable iff (!resetn)
    rx_byte && in_rx_ff && sts_ff[`SLRB_B_PROT] |=> sts_ff[`SLRB_B_OVR])
    else $error("overrun not flagged");
endmodule : slrb_bank
`default_nettype wire

/* File: shared/slrb_params.svh */
// Operation
// - Protect bit set: no receive stores; auto mode answers not-ready instead of ready.
// - Auto select bit picks auto mode, or addressed mode without control field; link clears.
// - Optional poll reply bit gates auto answer to unnumbered poll with poll zero.
// - Receive overrun flag in status bit 3, set and cleared by link logic.
// - Link sets interrupt flag bit 4, one CPU interrupt source, vector 23H.
// - Request-to-send bit 5: CPU reads and writes; link writes only in auto mode.
// - Receive-empty bit 6 enables receive; CPU sets it, link clears after a frame.
// - CPU sets transmit-full bit 7 after filling buffer; link may clear it.
// - Sequence register: send count 7:5, send error 4, receive count 3:1, error 0.
// - Receive error on count mismatch; send error unless equal or one ahead.
// - Non-auto mode leaves send and receive sequence counters untouched.
// - Transmit length gives information bytes; zero gives an empty field.
// - Buffer addressing never wraps; buffer end forced at RAM address 191.
// - Non-auto mode takes control field from transmit control byte register.
// - Receive area length gives allotted bytes, zero valid; written only when empty clear (code accepts CPU writes whatever bit 6 holds).
// - Reset clears status and sequence registers so link comes up idle.
// - No-control-field mode bit set means frames carry no control field.
`ifndef SLRB_PARAMS_SVH
`define SLRB_PARAMS_SVH
`define SLRB_ADDR_STS 8'hc8
`define SLRB_ADDR_RXLEN 8'hcb
`define SLRB_ADDR_RXPTR 8'hcc
`define SLRB_ADDR_STATION_ADDR 8'hce
`define SLRB_ADDR_SEQ 8'hd8
`define SLRB_ADDR_TCB 8'hda
`define SLRB_ADDR_TXLEN 8'hdb
`define SLRB_ADDR_TXPTR 8'hdc
`define SLRB_RST_BYTE 8'h00
`define SLRB_RST_CNT 3'h0
`define SLRB_BUF_END 8'hbf
`define SLRB_B_PROT 0
`define SLRB_B_AUTO 1
`define SLRB_B_OPB 2
`define SLRB_B_OVR 3
`define SLRB_B_IRQ 4
`define SLRB_B_RTS 5
`define SLRB_B_RXE 6
`define SLRB_B_TBF 7
`define SLRB_CTL_RR 4'h1
`define SLRB_CTL_RNR 4'h5
`define SLRB_INT_VECTOR 8'h23
`endif

/* File: shared/slrb_pkg.sv */
package slrb_pkg;
  typedef logic [7:0] slrb_byte_t;
  typedef logic [2:0] slrb_cnt_t;
  typedef enum logic [1:0] {
    SLRB_M_FLEX = 2'b00,
    SLRB_M_AUTO = 2'b01,
    SLRB_M_ADDR = 2'b11
  } slrb_mode_e;
endpackage : slrb_pkg

/* File: design/slrb_seq_check.sv */
`timescale 1ns/10ps
`default_nettype none
`include "slrb_params.svh"
module slrb_seq_check
  import slrb_pkg::*;
(
  input wire slrb_pkg::slrb_cnt_t local_ns, // Local send count
  input wire slrb_pkg::slrb_cnt_t local_nr, // Local receive count
  input wire slrb_pkg::slrb_cnt_t peer_ns, // Primary send count
  input wire slrb_pkg::slrb_cnt_t peer_nr, // Primary receive count
  output logic recv_err, // Receive count mismatch
  output logic send_err // Send count not acked
);
  import slrb_pkg::*;
  slrb_cnt_t ns_plus;
  // Modulo-eight successor wraps naturally in three bits
  assign ns_plus = slrb_cnt_t'(local_ns + 3'h1);
  // Mismatch tests
  assign recv_err = (peer_ns != local_nr);
  assign send_err = (peer_nr != local_ns) && (peer_nr != ns_plus);
endmodule : slrb_seq_check
`default_nettype wire

/* File: design/slrb_buf_addr.sv */
`timescale 1ns/10ps
`default_nettype none
`include "slrb_params.svh"
module slrb_buf_addr
  import slrb_pkg::*;
(
  input wire logic sys_clk, // System clock
  input wire logic resetn, // Sync reset, active low
  input wire logic start, // Load pointer pulse
  input wire slrb_pkg::slrb_byte_t base, // Start pointer
  input wire slrb_pkg::slrb_byte_t len, // Byte count
  input wire logic step, // Advance one byte
  output slrb_pkg::slrb_byte_t addr, // Current RAM address
  output logic active, // Bytes remain
  output logic buf_end // End reached
);
  import slrb_pkg::*;
  slrb_byte_t addr_ff;
  slrb_byte_t left_ff;
  logic end_ff;
  assign addr = addr_ff;
  assign active = (left_ff != `SLRB_RST_BYTE) && !end_ff;
  assign buf_end = end_ff;
  // Address walk; stops at top of RAM, never wraps
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      addr_ff <= `SLRB_RST_BYTE;
      left_ff <= `SLRB_RST_BYTE;
      end_ff <= 1'b0;
    end else if (start) begin
      addr_ff <= base;
      left_ff <= len;
      end_ff <= (len == `SLRB_RST_BYTE);
    end else if (step && active) begin
      left_ff <= slrb_byte_t'(left_ff - 8'h01);
      if (addr_ff == `SLRB_BUF_END) begin
        end_ff <= 1'b1;
      end else begin
        addr_ff <= slrb_byte_t'(addr_ff + 8'h01);
        end_ff <= (left_ff == 8'h01);
      end
    end
  end
  chk_no_wrap: assert property (@(posedge sys_clk) disable iff (!resetn)
    (addr_ff == `SLRB_BUF_END) && step && active && !start |=>
    end_ff && (addr_ff == `SLRB_BUF_END))
    else $error("buffer address passed its end");
  chk_zero_len: assert property (@(posedge sys_clk) disable iff (!resetn)
    start && (len == `SLRB_RST_BYTE) |=> !active)
    else $error("empty field still active");
endmodule : slrb_buf_addr
`default_nettype wire

/* File: tb/slrb_cpu_model.sv */
`timescale 1ns/10ps
`default_nettype none
module slrb_cpu_model
  import slrb_pkg::*;
(
  input wire logic sys_clk, // System clock
  output var slrb_pkg::slrb_byte_t sfr_addr, // Register address
  output var slrb_pkg::slrb_byte_t sfr_wdata, // Write data
  output var logic sfr_wr, // Write strobe
  input wire slrb_pkg::slrb_byte_t sfr_rdata // Read data
);
  // ----------------------------------------
  // Core side of the register port
  // ----------------------------------------
  // Idle bus at time zero
  initial begin
    sfr_addr = 8'h00;
    sfr_wdata = 8'h00;
    sfr_wr = 1'b0;
  end

  // Single-cycle write; no two-cycle access pair, link may write between them
  task automatic wr(input slrb_byte_t a, input slrb_byte_t d);
    @(posedge sys_clk);
    #1;
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(posedge sys_clk);
    #1;
    sfr_wr = 1'b0;
  endtask : wr

  // Read data is registered, so it lands one edge after the address
  task automatic rd(input slrb_byte_t a, output slrb_byte_t d);
    @(posedge sys_clk);
    #1;
    sfr_addr = a;
    @(posedge sys_clk);
    #1;
    d = sfr_rdata;
  endtask : rd
endmodule : slrb_cpu_model
`default_nettype wire

/* File: tb/slrb_bank_bench.sv */
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin err_count++; \
  $display("unexpected t=%0t got=%h exp=%h", $time, (g), (e)); end end
module slrb_bank_bench;
  import slrb_pkg::*;
  localparam int RXS = 0, RXB = 1, RXD = 2, TXS = 3, TXB = 4, TXD = 5;
  localparam int RSET = 6, RCLR = 7, LEAVE = 8, OSET = 9, OCLR = 10, OVC = 11;
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  logic sfr_wr, sfr_hit, ncf, rx_numbered, rx_opt_poll, rx_store_en, rx_buf_end, tx_more;
  logic tx_ctrl_present, opt_poll_answer, rts_out, link_irq, cap_store;
  slrb_byte_t sfr_addr, sfr_wdata, sfr_rdata, rx_ram_addr, tx_ram_addr, tx_ctrl, station_addr;
  slrb_byte_t cap_addr;
  slrb_cnt_t peer_ns, peer_nr;
  slrb_mode_e link_mode;
  logic [11:0] ev = 12'h000;
  logic [7:0] m [256];
  slrb_byte_t prm [7] = '{8'hcb, 8'hcc, 8'hce, 8'hd8, 8'hda, 8'hdb, 8'hdc};
  int err_count = 0;
  int cmp_count = 0;

  // ----------------------------------------
  // Clock, device and core model
  // ----------------------------------------
  always #10 sys_clk = ~sys_clk;
  slrb_cpu_model cpu (.sys_clk(sys_clk), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
    .sfr_wr(sfr_wr), .sfr_rdata(sfr_rdata));
  slrb_bank u_slrb_bank (.sys_clk(sys_clk), .resetn(resetn), .sfr_addr(sfr_addr),
    .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr), .sfr_rdata(sfr_rdata), .sfr_hit(sfr_hit),
    .no_control_field_mode(ncf), .rx_frame_start(ev[RXS]), .rx_byte(ev[RXB]),
    .rx_frame_done(ev[RXD]), .rx_numbered(rx_numbered), .peer_ns(peer_ns), .peer_nr(peer_nr),
    .rx_opt_poll(rx_opt_poll), .tx_frame_start(ev[TXS]), .tx_byte(ev[TXB]),
    .tx_frame_done(ev[TXD]), .auto_rts_set(ev[RSET]), .auto_rts_clr(ev[RCLR]),
    .auto_leave(ev[LEAVE]), .opb_set(ev[OSET]), .opb_clr(ev[OCLR]), .ovr_clr(ev[OVC]),
    .link_mode(link_mode), .rx_store_en(rx_store_en), .rx_ram_addr(rx_ram_addr),
    .rx_buf_end(rx_buf_end), .tx_ram_addr(tx_ram_addr), .tx_more(tx_more), .tx_ctrl(tx_ctrl),
    .tx_ctrl_present(tx_ctrl_present), .opt_poll_answer(opt_poll_answer),
    .station_addr(station_addr), .rts_out(rts_out), .link_irq(link_irq));

  // ----------------------------------------
  // Reference model and bus helpers
  // ----------------------------------------
  function automatic logic mapped(input slrb_byte_t a);
    foreach (prm[i]) if (prm[i] == a) return 1'b1;
    return a == 8'hc8;
  endfunction : mapped

  // Unmapped writes never reach the model, as the device ignores them
  task automatic wr(input slrb_byte_t a, input slrb_byte_t d);
    cpu.wr(a, d);
    if (mapped(a)) m[a] = d;
  endtask : wr

  task automatic rd(input slrb_byte_t a, input slrb_byte_t mask);
    slrb_byte_t d;
    cpu.rd(a, d);
    `CHK(d & mask, m[a] & mask)
    `CHK(sfr_hit, mapped(a))
  endtask : rd

  // One-cycle link pulse; comb outputs captured inside the pulse cycle
  task automatic pulse(input int i);
    @(posedge sys_clk);
    #1;
    ev[i] = 1'b1;
    #1;
    cap_store = rx_store_en;
    cap_addr = rx_ram_addr;
    @(posedge sys_clk);
    #1;
    ev = 12'h000;
  endtask : pulse

  task automatic close_out;
    $display("errors %0d comparisons %0d", err_count, cmp_count);
    if (err_count == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : close_out

  // Watchdog at ten thousand cycles, far past the few hundred the scenarios need
  initial begin
    #200000;
    err_count++;
    close_out();
  end

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    ncf = 1'b0;
    rx_numbered = 1'b0;
    rx_opt_poll = 1'b0;
    peer_ns = 3'h0;
    peer_nr = 3'h0;
    foreach (m[i]) m[i] = 8'h00;
    void'($urandom(32'h0ccee559));
    repeat (3) @(posedge sys_clk);
    #1;
    resetn = 1'b1;
    // Reset clears everything, unmapped reads zero
    for (int a = 8'hc8; a <= 8'hdc; a++) rd(8'(a), 8'hff);
    // Random parameter values while the link is idle
    foreach (prm[i]) wr(prm[i], 8'($urandom()));
    foreach (prm[i]) rd(prm[i], 8'hff);
    wr(8'hc9, 8'h5a);
    rd(8'hc9, 8'hff);
    `CHK(station_addr, m[8'hce])
    `CHK(tx_ctrl, m[8'hda])
    `CHK(link_mode, SLRB_M_FLEX)
    // Mode select and auto supervisory reply
    wr(8'hd8, 8'h00);
    wr(8'hc8, 8'h02);
    `CHK(link_mode, SLRB_M_AUTO)
    `CHK(tx_ctrl, 8'h11)
    `CHK(tx_ctrl_present, 1'b1)
    ncf = 1'b1;
    #1;
    `CHK(link_mode, SLRB_M_ADDR)
    `CHK(tx_ctrl_present, 1'b0)
    @(posedge sys_clk);
    #1;
    ncf = 1'b0;
    // Link edits of send request and optional poll bits
    pulse(RSET);
    m[8'hc8] = 8'h22;
    `CHK(rts_out, 1'b1)
    pulse(RCLR);
    `CHK(rts_out, 1'b0)
    pulse(OSET);
    m[8'hc8] = 8'h06;
    rx_opt_poll = 1'b1;
    #1;
    `CHK(opt_poll_answer, 1'b1)
    rd(8'hc8, 8'hff);
    pulse(OCLR);
    `CHK(opt_poll_answer, 1'b0)
    rx_opt_poll = 1'b0;
    pulse(LEAVE);
    m[8'hc8] = 8'h00;
    `CHK(link_mode, SLRB_M_FLEX)
    pulse(RSET);
    `CHK(rts_out, 1'b0)
    // Auto receive: one-byte area, second byte overruns
    wr(8'hcc, 8'h30);
    wr(8'hcb, 8'h01);
    wr(8'hd8, 8'he4);
    wr(8'hc8, 8'h42);
    pulse(RXS);
    pulse(RXB);
    `CHK(cap_store, 1'b1)
    `CHK(cap_addr, 8'h30)
    pulse(RXB);
    `CHK(cap_store, 1'b0)
    `CHK(rx_buf_end, 1'b1)
    rx_numbered = 1'b1;
    peer_ns = 3'h3;
    peer_nr = 3'h5;
    pulse(RXD);
    m[8'hc8] = 8'h1a;
    m[8'hd8] = 8'hf5;
    `CHK(link_irq, 1'b1)
    rd(8'hc8, 8'hff);
    rd(8'hd8, 8'h11);
    wr(8'hc8, 8'h02);
    `CHK(link_irq, 1'b0)
    // Clean numbered frame: receive count wraps, peer one ahead is no error
    wr(8'hd8, 8'h0e);
    wr(8'hc8, 8'h42);
    peer_ns = 3'h7;
    peer_nr = 3'h1;
    pulse(RXS);
    pulse(RXD);
    m[8'hc8] = 8'h12;
    m[8'hd8] = 8'h00;
    rd(8'hd8, 8'hff);
    rd(8'hc8, 8'hff);
    // Auto transmit near the RAM top, send count wraps
    wr(8'hd8, 8'he0);
    wr(8'hdc, 8'hbd);
    wr(8'hdb, 8'h05);
    wr(8'hc8, 8'h82);
    pulse(TXS);
    `CHK(tx_ram_addr, 8'hbd)
    `CHK(tx_more, 1'b1)
    repeat (4) pulse(TXB);
    `CHK(tx_ram_addr, 8'hbf)
    pulse(TXD);
    m[8'hc8] = 8'h12;
    m[8'hd8] = 8'h00;
    rd(8'hc8, 8'hff);
    rd(8'hd8, 8'he0);
    wr(8'hdb, 8'h00);
    pulse(TXS);
    `CHK(tx_more, 1'b0)
    // Protect bit: not-ready reply, no store, overrun
    wr(8'hd8, 8'h00);
    wr(8'hc8, 8'h43);
    `CHK(tx_ctrl, 8'h15)
    pulse(RXS);
    pulse(RXB);
    `CHK(cap_store, 1'b0)
    m[8'hc8] = 8'h4b;
    rd(8'hc8, 8'hff);
    pulse(OVC);
    m[8'hc8] = 8'h43;
    rd(8'hc8, 8'hff);
    // Non-auto frames leave the counters alone
    wr(8'hc8, 8'h00);
    wr(8'hcb, 8'h00);
    wr(8'hc8, 8'h40);
    wr(8'hd8, 8'he4);
    pulse(RXS);
    pulse(RXB);
    `CHK(cap_store, 1'b0)
    `CHK(rx_buf_end, 1'b1)
    pulse(RXD);
    pulse(TXD);
    m[8'hc8] = 8'h18;
    rd(8'hd8, 8'hee);
    rd(8'hc8, 8'hff);
    close_out();
  end
endmodule : slrb_bank_bench
`default_nettype wire
